// ---- ccg_pkg.sv ----
// constants for the cpu clock, wait and decode glue
package ccg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // clock division
  localparam int SRC_CLK_HZ = 10_000_000;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_SLOW = 4'h9;
  localparam logic [3:0] CNT_TOP = 4'hF;
  localparam logic [3:0] PRESET_FAST = CNT_TOP - DIV_FAST + 4'h1;
  localparam logic [3:0] PRESET_SLOW = CNT_TOP - DIV_SLOW + 4'h1;

  ////////////////////////////////////////////////////////////////////////
  // automatic low speed one-shot
  localparam int ONESHOT_TIME_US = 400;
  localparam int ONESHOT_CYC_DEF = ONESHOT_TIME_US * (SRC_CLK_HZ / 1_000_000);
  localparam int OS_W = 13;

  ////////////////////////////////////////////////////////////////////////
  // wait states, in cpu clock periods at high speed
  localparam logic [3:0] WAIT_ROM_STATES = 4'h1;
  localparam logic [3:0] WAIT_VID_STATES = 4'h1;
  localparam logic [3:0] WAIT_VID_HOLD_STATES = 4'h2;
  localparam int WCNT_W = 6;

  ////////////////////////////////////////////////////////////////////////
  // memory map
  localparam logic [15:0] ADR_ROM_LO = 16'h0000;
  localparam logic [15:0] ADR_ROM_HI = 16'h2FFF;
  localparam logic [15:0] ADR_COMM_STAT = 16'h37DE;
  localparam logic [15:0] ADR_COMM_DATA = 16'h37DF;
  localparam logic [15:0] ADR_INT_LATCH = 16'h37E0;
  localparam logic [15:0] ADR_DISK_SEL = 16'h37E1;
  localparam logic [15:0] ADR_CASS = 16'h37E4;
  localparam logic [15:0] ADR_PRINTER = 16'h37E8;
  localparam logic [15:0] ADR_FLOPPY = 16'h37EC;
  localparam logic [15:0] ADR_KBD_LO = 16'h3800;
  localparam logic [15:0] ADR_KBD_HI = 16'h38FF;
  localparam logic [15:0] ADR_VID_LO = 16'h3C00;
  localparam logic [15:0] ADR_VID_HI = 16'h3FFF;
  localparam logic [15:0] ADR_PRAM_LO = 16'h4000;
  localparam logic [15:0] ADR_PRAM_HI = 16'h7FFF;
  localparam logic [15:0] ADR_XRAM_LO = 16'h8000;
  localparam logic [15:0] ADR_XRAM_HI = 16'hFFFF;
  localparam logic [15:0] ADR_LOW16K_HI = 16'h3FFF;
  localparam logic [15:0] ADR_INT_RESTART = 16'h0038;
  localparam int PERIPH_N = 7;
  localparam int ADR_DEC_LSB = 12;
  localparam int ADR_ROM_PAIR_BIT = 11;
  localparam int ADR_REFRESH_W = 7;

  ////////////////////////////////////////////////////////////////////////
  // register map on the bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_HIRES_EN = 0;
  localparam int CTRL_SOFT_SLOW = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_FAST = 0;
  localparam int STAT_ONESHOT = 1;
  localparam int STAT_BUS_GRANT = 2;
  localparam int STAT_RESTART = 3;
  localparam int STAT_WAITING = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_COUNT = 2'b01,
    W_HOLD = 2'b10
  } ccg_wait_t;

endpackage

// ---- ccg_top.sv ----
// cpu clock divider, wait generator, strobe gating and memory decoder
`timescale 1ns/1ps

// Contract
// - cpu clock: source divided by four or nine
// - forced slow low loads divide-by-nine preset
// - high speed loads divide-by-four preset
// - fast indicator low; rom read adds wait
// - floppy access fires one-shot forcing slow speed
// - upper address latched; low seven carry refresh
// - data buffer toward cpu when direction high
// - fast waits: rom one, video one/two, ram none
// - wait hold lengthens video read waits
// - expansion wait request stalls the cpu
// - interrupt mode one restarts at 0038
// - bus request floats cpu and buffers
// - read strobes: direction, internal, external qualified
// - write strobes: internal, external qualified
// - qualifier masks rom and video selects in low 16K under hires graphics
// - io strobes, interrupt acknowledge
// - refresh clears mux, column strobe held high
// - 3-to-8 decoder on A15, request, A12-A14
// - single peripheral addresses decoded
// - keyboard, video, program, expansion regions decoded
// - six 2K roms from 0 to 12K
// - 4K region select, A11 picks device
module ccg_top
  import ccg_pkg::*;
#(
  parameter int ONESHOT_CYCLES = ONESHOT_CYC_DEF
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // board pins
  input wire logic i_speed_switch,
  input wire logic i_auto_speed_select,
  input wire logic i_wait_extend_hold,
  input wire logic i_exp_wait_n,
  input wire logic i_exp_busreq_n,
  input wire logic i_int_req_n,
  // cpu side
  input wire logic [15:0] i_cpu_addr,
  input wire logic i_cpu_read_n,
  input wire logic i_cpu_write_n,
  input wire logic i_cpu_mem_request_n,
  input wire logic i_cpu_io_request_n,
  input wire logic i_cpu_opcode_fetch_n,
  input wire logic i_refresh_cycle_n,
  input wire logic i_cpu_busack_n,
  output logic o_cpu_clk,
  output logic o_cpu_wait_n,
  output logic o_cpu_int_n,
  output logic o_cpu_busreq_n,
  output logic o_fast_speed_n,
  output logic o_forced_slow_n,
  // buffers and address
  output logic o_data_in_direction,
  output logic o_buf_oe_n,
  output logic [15:0] o_addr,
  output logic o_row_col_select,
  output logic o_col_strobe_n,
  // strobes
  output logic o_internal_mem_read_n,
  output logic o_internal_mem_write_n,
  output logic o_external_read_out_n,
  output logic o_external_write_out_n,
  output logic o_low_mem_disable_qual,
  output logic o_io_output_strobe_n,
  output logic o_io_input_strobe_n,
  output logic o_int_ack_n,
  // decoder selects
  output logic [7:0] o_mem_dec_n,
  output logic [5:0] o_rom_dev_n,
  output logic [PERIPH_N-1:0] o_periph_sel_n,
  output logic o_keyboard_sel_n,
  output logic o_video_sel_n,
  output logic o_prog_ram_sel_n,
  output logic o_exp_ram_sel_n
);

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [WCNT_W-1:0] wait_cycles(input logic [3:0] n);
    wait_cycles = WCNT_W'(n) * WCNT_W'(DIV_FAST);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  wire [5:0] pin_raw = {i_speed_switch, i_auto_speed_select,
                        i_wait_extend_hold, i_exp_wait_n,
                        i_exp_busreq_n, i_int_req_n};

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pin_s1_r <= 6'h0F;
      pin_s2_r <= 6'h0F;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  wire speed_switch = pin_s2_r[5];
  wire auto_speed_select = pin_s2_r[4];
  wire wait_extend_hold = pin_s2_r[3];
  wire exp_wait_n = pin_s2_r[2];
  wire exp_busreq_n = pin_s2_r[1];
  wire int_req_n = pin_s2_r[0];

  //////////////////////////////////////////////////////////////////////////
  // cpu cycle decode
  wire mreq = !i_cpu_mem_request_n;
  wire ioreq = !i_cpu_io_request_n;
  wire rd = !i_cpu_read_n;
  wire wr = !i_cpu_write_n;
  wire refresh = !i_refresh_cycle_n;
  wire bus_grant = !i_cpu_busack_n;
  wire [15:0] a = i_cpu_addr;

  logic [1:0] ctrl_r;
  wire hires_en = ctrl_r[CTRL_HIRES_EN];
  wire low16k = in_range(a, ADR_ROM_LO, ADR_LOW16K_HI);
  wire qual = hires_en && low16k;

  wire dec_en = !a[15] && mreq && !refresh;
  wire [2:0] dec_sel = a[ADR_DEC_LSB+2:ADR_DEC_LSB];
  wire [7:0] dec_hot = dec_en ? (8'h01 << dec_sel) : 8'h00;
  wire rom_hit = dec_en && in_range(a, ADR_ROM_LO, ADR_ROM_HI)
                 && !qual;
  wire [2:0] rom_region = dec_hot[2:0] & {3{rom_hit}};
  wire pair_hi = a[ADR_ROM_PAIR_BIT];
  wire [5:0] rom_dev = {rom_region[2] && pair_hi,
                        rom_region[2] && !pair_hi,
                        rom_region[1] && pair_hi,
                        rom_region[1] && !pair_hi,
                        rom_region[0] && pair_hi,
                        rom_region[0] && !pair_hi};

  wire mem_acc = mreq && !refresh;
  wire [PERIPH_N-1:0] periph = {a == ADR_FLOPPY, a == ADR_PRINTER,
                                a == ADR_CASS, a == ADR_DISK_SEL,
                                a == ADR_INT_LATCH, a == ADR_COMM_DATA,
                                a == ADR_COMM_STAT};
  wire kbd_hit = mem_acc && in_range(a, ADR_KBD_LO, ADR_KBD_HI);
  wire vid_hit = mem_acc && in_range(a, ADR_VID_LO, ADR_VID_HI)
                 && !qual;
  wire pram_hit = mem_acc && in_range(a, ADR_PRAM_LO, ADR_PRAM_HI);
  wire xram_hit = mem_acc && in_range(a, ADR_XRAM_LO, ADR_XRAM_HI);
  wire floppy_hit = mem_acc && periph[PERIPH_N-1];

  //////////////////////////////////////////////////////////////////////////
  // registered strobes and selects
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_data_in_direction <= 1'b0;
      o_internal_mem_read_n <= 1'b1;
      o_internal_mem_write_n <= 1'b1;
      o_external_read_out_n <= 1'b1;
      o_external_write_out_n <= 1'b1;
      o_low_mem_disable_qual <= 1'b0;
      o_io_output_strobe_n <= 1'b1;
      o_io_input_strobe_n <= 1'b1;
      o_int_ack_n <= 1'b1;
      o_mem_dec_n <= 8'hFF;
      o_rom_dev_n <= 6'h3F;
      o_periph_sel_n <= '1;
      o_keyboard_sel_n <= 1'b1;
      o_video_sel_n <= 1'b1;
      o_prog_ram_sel_n <= 1'b1;
      o_exp_ram_sel_n <= 1'b1;
    end
    else
    begin
      o_data_in_direction <= rd;
      o_internal_mem_read_n <= !(rd && mreq);
      o_internal_mem_write_n <= !(wr && mreq);
      o_external_read_out_n <= !(rd && mreq && qual);
      o_external_write_out_n <= !(wr && mreq && qual);
      o_low_mem_disable_qual <= qual;
      o_io_output_strobe_n <= !(ioreq && wr);
      o_io_input_strobe_n <= !(ioreq && rd);
      o_int_ack_n <= !(ioreq && !i_cpu_opcode_fetch_n);
      o_mem_dec_n <= ~dec_hot;
      o_rom_dev_n <= ~rom_dev;
      o_periph_sel_n <= ~(periph & {PERIPH_N{mem_acc}});
      o_keyboard_sel_n <= !kbd_hit;
      o_video_sel_n <= !vid_hit;
      o_prog_ram_sel_n <= !pram_hit;
      o_exp_ram_sel_n <= !xram_hit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address latch, refresh steering, bus takeover
  logic mreq_d_r;
  wire upper_open = !(mreq || ioreq) || refresh;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_addr <= 16'h0000;
      mreq_d_r <= 1'b0;
      o_row_col_select <= 1'b0;
      o_col_strobe_n <= 1'b1;
      o_cpu_busreq_n <= 1'b1;
      o_buf_oe_n <= 1'b0;
      o_cpu_int_n <= 1'b1;
    end
    else
    begin
      o_addr[ADR_REFRESH_W-1:0] <= a[ADR_REFRESH_W-1:0];
      if (upper_open)
      begin
        o_addr[15:ADR_REFRESH_W] <= a[15:ADR_REFRESH_W];
      end
      mreq_d_r <= mreq;
      o_row_col_select <= !refresh && mreq && mreq_d_r;
      o_col_strobe_n <= refresh || !(o_row_col_select && mreq);
      o_cpu_busreq_n <= exp_busreq_n;
      o_buf_oe_n <= bus_grant;
      o_cpu_int_n <= int_req_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt restart tracking
  logic ack_seen_r;
  logic restart_r;
  logic restart_clr;
  wire restart_hit = ack_seen_r && mreq && !i_cpu_opcode_fetch_n
                     && (a == ADR_INT_RESTART);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ack_seen_r <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      if (ioreq && !i_cpu_opcode_fetch_n)
        ack_seen_r <= 1'b1;
      else if (restart_hit || (mreq && !i_cpu_opcode_fetch_n))
        ack_seen_r <= 1'b0;
      restart_r <= restart_hit || (restart_r && !restart_clr);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // automatic low speed one-shot
  logic [OS_W-1:0] os_cnt_r;
  wire os_fire = auto_speed_select && floppy_hit;
  wire os_active = os_cnt_r != '0;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      os_cnt_r <= '0;
    else if (os_fire)
      os_cnt_r <= OS_W'(ONESHOT_CYCLES);
    else if (os_active)
      os_cnt_r <= os_cnt_r - OS_W'(1);
  end

  //////////////////////////////////////////////////////////////////////////
  // cpu clock divider
  logic [3:0] div_cnt_r;
  logic [3:0] half_r;
  logic fast_r;
  wire forced_slow_n = !(speed_switch || os_active || ctrl_r[CTRL_SOFT_SLOW]);
  wire div_wrap = div_cnt_r == CNT_TOP;
  wire [3:0] preset = forced_slow_n ? PRESET_FAST : PRESET_SLOW;
  wire [3:0] ratio = forced_slow_n ? DIV_FAST : DIV_SLOW;
  wire [3:0] div_nxt = div_wrap ? preset : div_cnt_r + 4'h1;
  wire [3:0] half_nxt = div_wrap ? preset + (ratio >> 1) : half_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      div_cnt_r <= PRESET_FAST;
      half_r <= PRESET_FAST + (DIV_FAST >> 1);
      fast_r <= 1'b1;
      o_cpu_clk <= 1'b1;
      o_fast_speed_n <= 1'b0;
      o_forced_slow_n <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_nxt;
      half_r <= half_nxt;
      o_cpu_clk <= div_nxt < half_nxt;
      if (div_wrap)
        fast_r <= forced_slow_n;
      if (div_wrap)
        o_fast_speed_n <= !forced_slow_n;
      o_forced_slow_n <= forced_slow_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wait generator
  ccg_wait_t wst_r;
  ccg_wait_t wst_nxt;
  logic [WCNT_W-1:0] wcnt_r;
  logic [WCNT_W-1:0] wcnt_nxt;
  logic acc_d_r;
  wire acc = mreq && (rd || wr) && !refresh;
  wire acc_start = acc && !acc_d_r;
  wire rom_rd = rom_hit && rd;
  wire vid_rd_hold = vid_hit && rd && wait_extend_hold;
  wire [3:0] wst_count = rom_rd ? WAIT_ROM_STATES :
                         vid_rd_hold ? WAIT_VID_HOLD_STATES :
                         WAIT_VID_STATES;
  wire need_wait = fast_r && (rom_rd || vid_hit);

  always_comb
  begin
    wst_nxt = wst_r;
    wcnt_nxt = wcnt_r;
    case (wst_r)
      W_IDLE:
      begin
        if (acc_start && need_wait)
        begin
          wst_nxt = W_COUNT;
          wcnt_nxt = wait_cycles(wst_count);
        end
      end
      W_COUNT:
      begin
        if (wcnt_r > WCNT_W'(1))
          wcnt_nxt = wcnt_r - WCNT_W'(1);
        else if (!vid_rd_hold)
          wst_nxt = W_HOLD;
      end
      W_HOLD:
      begin
        if (!acc)
          wst_nxt = W_IDLE;
      end
      default:
        wst_nxt = W_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wst_r <= W_IDLE;
      wcnt_r <= '0;
      acc_d_r <= 1'b0;
      o_cpu_wait_n <= 1'b1;
    end
    else
    begin
      wst_r <= wst_nxt;
      wcnt_r <= wcnt_nxt;
      acc_d_r <= acc;
      o_cpu_wait_n <= (wst_nxt != W_COUNT) && exp_wait_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave, zero wait states
  logic aph_wr_r;
  logic [7:0] aph_addr_r;
  wire aph_valid = i_hsel && i_hready &&
                   (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
  wire hit_ctrl = aph_addr_r == REG_CTRL;
  wire hit_stat = aph_addr_r == REG_STATUS;
  wire [31:0] status_word = {27'h0, !o_cpu_wait_n, restart_r, bus_grant,
                             os_active, fast_r};
  wire [7:0] req_addr = {i_haddr[7:2], 2'b00};
  wire [31:0] rd_word = req_addr == REG_CTRL ? {30'h0, ctrl_r} :
                        req_addr == REG_STATUS ? status_word : 32'h0;
  assign restart_clr = aph_wr_r && hit_stat && i_hwdata[STAT_RESTART];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      aph_wr_r <= 1'b0;
      aph_addr_r <= 8'h00;
      ctrl_r <= CTRL_RESET;
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
    else
    begin
      aph_wr_r <= aph_valid && i_hwrite;
      if (aph_valid)
        aph_addr_r <= req_addr;
      if (aph_wr_r && hit_ctrl)
        ctrl_r <= i_hwdata[1:0];
      if (aph_valid && !i_hwrite)
        o_hrdata <= rd_word;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

endmodule

// ---- ccg_cpu_model.sv ----
// behavioural processor core and bus master facing the glue
`timescale 1ns/1ps

module ccg_cpu_model
  import ccg_pkg::*;
(
  // clock and bus request from the glue
  input wire logic i_clk,
  input wire logic i_busreq_n,
  // processor pins
  output logic [15:0] o_addr,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_mreq_n,
  output logic o_iorq_n,
  output logic o_m1_n,
  output logic o_refresh_cycle_n_n,
  output logic o_busack_n
);

  initial
  begin
    o_addr = 16'h0000;
    {o_rd_n, o_wr_n, o_mreq_n, o_iorq_n, o_m1_n, o_refresh_cycle_n_n} = 6'h3F;
    o_busack_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // grant one cycle after the request
  always @(posedge i_clk)
    o_busack_n <= i_busreq_n;

  ////////////////////////////////////////////////////////////////////////
  // kinds: 0 mem rd, 1 mem wr, 2 io wr, 3 io rd, 4 int ack, 5 refresh
  task go(input int k, input logic [15:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_mreq_n <= !(k < 2 || k == 5);
    o_rd_n <= !(k == 0 || k == 3);
    o_wr_n <= !(k == 1 || k == 2);
    o_iorq_n <= !(k > 1 && k < 5);
    o_m1_n <= k != 4;
    o_refresh_cycle_n_n <= k != 5;
  endtask

  // released address lines no longer show the old value
  task stop;
    @(posedge i_clk);
    {o_rd_n, o_wr_n, o_mreq_n, o_iorq_n, o_m1_n, o_refresh_cycle_n_n} <= 6'h3F;
    o_addr <= ~o_addr;
  endtask

endmodule

// ---- ccg_props.sv ----
// concurrent checks on the glue's cpu-side ports
`timescale 1ns/1ps

module ccg_props
  import ccg_pkg::*;
#(
  parameter int ONESHOT_CYCLES = 20
)
(
  // clock and reset
  input logic i_clk,
  input logic i_rst_n,
  // cpu side inputs
  input logic [15:0] i_cpu_addr,
  input logic i_cpu_read_n,
  input logic i_cpu_write_n,
  input logic i_cpu_mem_request_n,
  input logic i_cpu_io_request_n,
  input logic i_cpu_opcode_fetch_n,
  input logic i_refresh_cycle_n,
  input logic i_cpu_busack_n,
  // outputs watched
  input logic o_cpu_clk,
  input logic o_cpu_wait_n,
  input logic o_fast_speed_n,
  input logic o_data_in_direction,
  input logic o_buf_oe_n,
  input logic o_row_col_select,
  input logic o_col_strobe_n,
  input logic o_internal_mem_read_n,
  input logic o_io_output_strobe_n,
  input logic o_io_input_strobe_n,
  input logic o_int_ack_n,
  input logic [7:0] o_mem_dec_n,
  input logic [PERIPH_N-1:0] o_periph_sel_n
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wire mrq = !i_cpu_mem_request_n && i_refresh_cycle_n;
  wire io_rq = !i_cpu_io_request_n;

  a_mem_read: assert property (!i_cpu_read_n && mrq |=>
    !o_internal_mem_read_n) else $error("memory read strobe missing");
  a_io_out: assert property (io_rq && !i_cpu_write_n |=>
    !o_io_output_strobe_n) else $error("io output strobe missing");
  a_io_in: assert property (io_rq && !i_cpu_read_n |=>
    !o_io_input_strobe_n) else $error("io input strobe missing");
  a_int_ack: assert property (io_rq && !i_cpu_opcode_fetch_n |=>
    !o_int_ack_n) else $error("interrupt acknowledge missing");
  a_dir_follow: assert property (1'b1 |=>
    o_data_in_direction == !$past(i_cpu_read_n))
    else $error("buffer direction wrong");
  a_floppy_sel: assert property (mrq && i_cpu_addr == ADR_FLOPPY |=>
    !o_periph_sel_n[6]) else $error("floppy select missing");
  a_dec_onehot: assert property (mrq && !i_cpu_addr[15] |=>
    o_mem_dec_n == ~(8'h01 << $past(i_cpu_addr[14:12])))
    else $error("memory decoder output wrong");
  a_refresh_mux: assert property (!i_refresh_cycle_n |=>
    !o_row_col_select && o_col_strobe_n) else $error("refresh mux wrong");
  a_buf_float: assert property (!i_cpu_busack_n |=> o_buf_oe_n)
    else $error("buffers still driving");
  a_fast_period: assert property ($rose(o_cpu_clk) && !o_fast_speed_n
    && $stable(o_fast_speed_n) |-> ##4 $rose(o_cpu_clk))
    else $error("fast clock period wrong");
  a_slow_period: assert property ($rose(o_cpu_clk) && o_fast_speed_n
    && $stable(o_fast_speed_n) |-> ##9 $rose(o_cpu_clk))
    else $error("slow clock period wrong");
  a_rom_wait: assert property ($fell(i_cpu_mem_request_n)
    && !i_cpu_read_n && i_cpu_addr <= ADR_ROM_HI && !o_fast_speed_n
    |=> !o_cpu_wait_n [*4]) else $error("rom wait wrong");

  c_wait: cover property ($fell(o_cpu_wait_n));
  c_grant: cover property ($rose(o_buf_oe_n));
  c_refresh: cover property (!i_refresh_cycle_n);

endmodule

bind ccg_top ccg_props #(.ONESHOT_CYCLES(ONESHOT_CYCLES)) u_props (
  .i_clk, .i_rst_n, .i_cpu_addr, .i_cpu_read_n, .i_cpu_write_n,
  .i_cpu_mem_request_n, .i_cpu_io_request_n, .i_cpu_opcode_fetch_n,
  .i_refresh_cycle_n, .i_cpu_busack_n, .o_cpu_clk, .o_cpu_wait_n,
  .o_fast_speed_n, .o_data_in_direction, .o_buf_oe_n, .o_row_col_select,
  .o_col_strobe_n, .o_internal_mem_read_n, .o_io_output_strobe_n,
  .o_io_input_strobe_n, .o_int_ack_n, .o_mem_dec_n, .o_periph_sel_n
);

// ---- cpu_clock_wait_decode_glue_tb_top.sv ----
// self-checking bench for the clock, wait and decode glue
`timescale 1ns/1ps

module cpu_clock_wait_decode_glue_tb_top
  import ccg_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic i_speed_switch = 1'b0;
  logic i_auto_speed_select = 1'b0;
  logic i_wait_extend_hold = 1'b0;
  logic i_exp_wait_n = 1'b1;
  logic i_exp_busreq_n = 1'b1;
  logic i_int_req_n = 1'b1;
  logic [15:0] i_cpu_addr, o_addr;
  logic i_cpu_read_n, i_cpu_write_n, i_cpu_mem_request_n;
  logic i_cpu_io_request_n, i_cpu_opcode_fetch_n, i_refresh_cycle_n;
  logic i_cpu_busack_n, o_hreadyout, o_hresp, o_cpu_clk, o_cpu_wait_n;
  logic o_cpu_int_n, o_cpu_busreq_n, o_fast_speed_n, o_forced_slow_n;
  logic o_data_in_direction, o_buf_oe_n, o_row_col_select, o_col_strobe_n;
  logic o_internal_mem_read_n, o_internal_mem_write_n, o_int_ack_n;
  logic o_external_read_out_n, o_external_write_out_n;
  logic o_low_mem_disable_qual, o_io_output_strobe_n, o_io_input_strobe_n;
  logic o_keyboard_sel_n, o_video_sel_n, o_prog_ram_sel_n, o_exp_ram_sel_n;
  logic [31:0] o_hrdata;
  logic [7:0] o_mem_dec_n;
  logic [5:0] o_rom_dev_n;
  logic [PERIPH_N-1:0] o_periph_sel_n;
  logic [31:0] q;
  logic [15:0] pa [7] = '{ADR_COMM_STAT, ADR_COMM_DATA, ADR_INT_LATCH,
    ADR_DISK_SEL, ADR_CASS, ADR_PRINTER, ADR_FLOPPY};
  logic [15:0] ra [8] = '{16'h3800, 16'h38FF, 16'h3C00, 16'h3FFF,
    16'h4000, 16'h7FFF, 16'h8000, 16'hFFFF};
  int fail_count = 0;
  int samples_checked = 0;
  int c;

  always #50 i_clk = ~i_clk;

  ccg_top #(.ONESHOT_CYCLES(20)) uut (.*, .i_hsize(3'h2),
    .i_hready(o_hreadyout));

  ccg_cpu_model cpu (.i_clk, .i_busreq_n(o_cpu_busreq_n),
    .o_addr(i_cpu_addr), .o_rd_n(i_cpu_read_n), .o_wr_n(i_cpu_write_n),
    .o_mreq_n(i_cpu_mem_request_n), .o_iorq_n(i_cpu_io_request_n),
    .o_m1_n(i_cpu_opcode_fetch_n), .o_refresh_cycle_n_n(i_refresh_cycle_n),
    .o_busack_n(i_cpu_busack_n));

  ////////////////////////////////////////////////////////////////////////
  // helpers
  task wrap_up;
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      $display("mismatch at %0t: got %h, expected %h", $time, g, e);
      fail_count++;
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task hwait;
    int k;
    k = 0;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1 && k < 50)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k == 50)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  // one ahb single word transfer, read data taken as the data phase ends
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_hsel <= 1'b1;
    i_htrans <= HTRANS_NONSEQ;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    hwait();
    i_htrans <= 2'h0;
    i_hwdata <= d;
    hwait();
    i_hsel <= 1'b0;
    q = o_hrdata;
    chk(o_hresp, 0);
  endtask

  task up(inout int p);
    while (o_cpu_clk !== 1'b0 && p < 40)
    begin
      tick(1);
      p++;
    end
    while (o_cpu_clk !== 1'b1 && p < 40)
    begin
      tick(1);
      p++;
    end
  endtask

  task per(output int p);
    p = 0;
    up(p);
    p = 0;
    up(p);
  endtask

  task wcnt(input int k, input logic [15:0] a);
    cpu.go(k, a);
    c = 0;
    repeat (30)
    begin
      tick(1);
      if (o_cpu_wait_n === 1'b0)
        c++;
    end
    cpu.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    tick(3);
    bus(0, REG_CTRL, 0);
    chk(q, 0);
    bus(1, 8'h08, 32'hFFFF_FFFF);
    bus(0, 8'h08, 0);
    chk(q, 0);
    bus(1, REG_CTRL, 32'h1);
    bus(0, REG_CTRL, 0);
    chk(q, 1);
    for (int k = 0; k < 5; k++)
    begin
      cpu.go(k, 16'h4000);
      tick(2);
      chk({o_internal_mem_read_n, o_internal_mem_write_n,
        o_io_output_strobe_n, o_io_input_strobe_n, o_int_ack_n},
        5'(~(5'h10 >> k)));
      chk(o_data_in_direction, k == 0 || k == 3);
      cpu.stop();
    end
    @(posedge i_clk);
    i_speed_switch <= 1'b1;
    tick(30);
    per(c);
    chk(c, DIV_SLOW);
    chk({o_forced_slow_n, o_fast_speed_n}, 2'b01);
    cpu.go(0, 16'h1000);
    tick(2);
    chk({o_low_mem_disable_qual, o_internal_mem_read_n,
      o_external_read_out_n}, 3'b100);
    cpu.stop();
    cpu.go(1, 16'h1000);
    tick(2);
    chk({o_low_mem_disable_qual, o_internal_mem_write_n,
      o_external_write_out_n}, 3'b100);
    cpu.stop();
    bus(1, REG_CTRL, 0);
    wcnt(0, 16'h0000);
    chk(c, 0);
    chk({o_low_mem_disable_qual, o_external_read_out_n}, 2'b01);
    @(posedge i_clk);
    i_speed_switch <= 1'b0;
    tick(30);
    per(c);
    chk(c, DIV_FAST);
    chk(o_fast_speed_n, 0);
    wcnt(0, 16'h0000);
    chk(c, WAIT_ROM_STATES * DIV_FAST);
    wcnt(1, ADR_VID_LO);
    chk(c, WAIT_VID_STATES * DIV_FAST);
    wcnt(0, ADR_VID_HI);
    chk(c, WAIT_VID_STATES * DIV_FAST);
    wcnt(0, ADR_PRAM_LO);
    chk(c, 0);
    @(posedge i_clk);
    i_wait_extend_hold <= 1'b1;
    wcnt(0, ADR_VID_LO);
    chk(c >= WAIT_VID_HOLD_STATES * DIV_FAST, 1);
    i_wait_extend_hold <= 1'b0;
    i_exp_wait_n <= 1'b0;
    tick(5);
    chk(o_cpu_wait_n, 0);
    @(posedge i_clk);
    i_exp_wait_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      cpu.go(0, pa[i]);
      tick(2);
      chk(o_periph_sel_n, 7'(~(7'h01 << i)));
      cpu.stop();
    end
    for (int i = 0; i < 8; i++)
    begin
      cpu.go(0, ra[i]);
      tick(5);
      chk({o_keyboard_sel_n, o_video_sel_n, o_prog_ram_sel_n,
        o_exp_ram_sel_n}, 4'(~(4'h8 >> (i / 2))));
      cpu.stop();
      cpu.go(0, {1'b0, 3'(i), 1'(i), 11'h000});
      tick(5);
      chk(o_mem_dec_n, 8'(~(8'h01 << i)));
      chk(o_rom_dev_n, i < 3 ? 6'(~(6'h01 << (2 * i + i % 2)))
        : 6'h3F);
      cpu.stop();
    end
    cpu.go(5, 16'h4055);
    tick(2);
    chk({o_row_col_select, o_col_strobe_n, o_mem_dec_n}, 10'h1FF);
    chk(o_addr[6:0], 7'h55);
    cpu.stop();
    i_exp_busreq_n <= 1'b0;
    tick(6);
    chk({o_cpu_busreq_n, o_buf_oe_n}, 2'b01);
    bus(0, REG_STATUS, 0);
    chk(q[STAT_BUS_GRANT], 1);
    cpu.go(5, 16'h0033);
    tick(2);
    chk({o_row_col_select, o_col_strobe_n}, 2'b01);
    cpu.stop();
    i_exp_busreq_n <= 1'b1;
    i_int_req_n <= 1'b0;
    tick(6);
    chk({o_buf_oe_n, o_cpu_int_n}, 2'b00);
    @(posedge i_clk);
    i_int_req_n <= 1'b1;
    i_auto_speed_select <= 1'b1;
    tick(4);
    cpu.go(0, ADR_FLOPPY);
    tick(3);
    chk(o_forced_slow_n, 0);
    cpu.stop();
    tick(6);
    chk(o_fast_speed_n, 1);
    tick(60);
    chk({o_forced_slow_n, o_fast_speed_n}, 2'b10);
    per(c);
    chk(c, DIV_FAST);
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    wrap_up();
  end

endmodule
